// File: logic/oomc_pkg.sv
package oomc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK = 8'h04;
   localparam logic [7:0] OFS_ACC_LOW = 8'h08;
   localparam logic [7:0] OFS_ACC_HIGH = 8'h0c;
   localparam logic [7:0] OFS_ACC_UPPER = 8'h10;
   localparam logic [7:0] OFS_INC_LOW = 8'h14;
   localparam logic [7:0] OFS_INC_HIGH = 8'h18;
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h1c;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
   // control register fields
   localparam int BIT_MODULE_ON = 7;
   localparam int BIT_PIN_DRIVE = 6;
   localparam int BIT_OUT_STATUS = 5;
   localparam int BIT_INVERT = 4;
   localparam int BIT_PULSE_MODE = 0;
   // clock control fields
   localparam int PWS_LSB = 5;
   localparam int CKS_LSB = 0;
   // irq fields
   localparam int BIT_IRQ_FLAG = 0;
   localparam int BIT_IRQ_IE = 0;
   localparam int BIT_IRQ_PIE = 1;
   localparam int BIT_IRQ_GIE = 2;
   // widths and reset values
   localparam int ACC_W = 20;
   localparam int INC_W = 16;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [19:0] RST_ACC = 20'h00000;
   localparam logic [15:0] RST_INC = 16'h0000;
   localparam logic [7:0] RST_PULSE_COUNT = 8'h00;
   // oscillator ticks from a low increment write to the buffer load
   localparam logic [1:0] INC_LOAD_TICKS = 2'h2;
   typedef enum logic [1:0] {
      OOMC_CKS_FAST_OSC,
      OOMC_CKS_SYSTEM,
      OOMC_CKS_LOGIC_CELL1,
      OOMC_CKS_CLOCK_PIN
   } oomc_cks_t;
endpackage

// File: logic/oomc_accum.sv
`timescale 1ns/1ps
module oomc_accum (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic osc_tick,
   input wire logic module_on,
   input wire logic inc_low_wr,
   input wire logic [oomc_pkg::INC_W-1:0] inc_wdata,
   input wire logic acc_wr,
   input wire logic [oomc_pkg::ACC_W-1:0] acc_wdata,
   output logic [oomc_pkg::ACC_W-1:0] acc,
   output logic accumulator_carry
);
   import oomc_pkg::*;

   logic [ACC_W-1:0] next_acc;
   logic [INC_W-1:0] inc_buf;
   logic [INC_W-1:0] next_inc_buf;
   logic [INC_W-1:0] inc_pend;
   logic [INC_W-1:0] next_inc_pend;
   logic [1:0] load_count;
   logic [1:0] next_load_count;
   logic [ACC_W:0] sum;

   always_comb begin
      sum = {1'b0, acc} + {{(ACC_W + 1 - INC_W){1'b0}}, inc_buf};
      accumulator_carry = osc_tick & sum[ACC_W]; // RULE_20
      next_acc = acc;
      next_inc_buf = inc_buf;
      next_inc_pend = inc_pend;
      next_load_count = load_count;
      if (osc_tick) begin
         next_acc = sum[ACC_W-1:0]; // RULE_20
      end
      if (acc_wr) begin
         next_acc = acc_wdata;
      end
      if (load_count != 2'h0 && osc_tick) begin
         next_load_count = load_count - 2'h1;
         if (load_count == 2'h1) begin
            next_inc_buf = inc_pend; // RULE_23
         end
      end
      if (inc_low_wr) begin
         if (module_on) begin
            next_inc_pend = inc_wdata;
            next_load_count = INC_LOAD_TICKS; // RULE_23
         end else begin
            next_inc_buf = inc_wdata; // RULE_23
            next_load_count = 2'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc <= RST_ACC; // RULE_15
         inc_buf <= RST_INC;
         inc_pend <= RST_INC;
         load_count <= 2'h0;
      end else begin
         acc <= next_acc;
         inc_buf <= next_inc_buf;
         inc_pend <= next_inc_pend;
         load_count <= next_load_count;
      end
   end
endmodule

// File: logic/oomc_top.sv
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
//Contract
// RULE_01: toggle mode inverts the output on every accumulator overflow, 50% duty.
// RULE_02: pulse-mode select bit 0 clear selects toggle mode.
// RULE_03: pulse mode holds output active for selected oscillator periods after overflow.
// RULE_04: pulse output goes active on the oscillator edge after the overflow.
// RULE_05: pulse-mode select bit set selects pulse mode.
// RULE_06: three-bit pulse width field in clock control sets active length.
// RULE_07: software keeps pulse width shorter than the overflow interval.
// RULE_08: invert bit 4 flips the final output as the last stage.
// RULE_09: polarity change with interrupts enabled raises an interrupt.
// RULE_10: read-only status bit 5 shows the current output level.
// RULE_11: final output goes to logic cell and waveform generator.
// RULE_12: every overflow sets the overflow interrupt flag.
// RULE_13: request needs module on, irq enable, peripheral enable, global enable.
// RULE_14: software clears the flag; hardware never clears it.
// RULE_15: every register of the module clears to zero on reset.
// RULE_16: module keeps running in sleep on its selected clock.
// RULE_17: enabled with fast oscillator selected keeps that oscillator running.
// RULE_18: enable bit 7 turns the module on or off.
// RULE_19: pin drive bit 6 connects the output to its pin.
// RULE_20: 20-bit accumulator adds 16-bit increment each tick; carry is overflow.
// RULE_21: width codes 0..7 give 1,2,4,...,128 oscillator periods.
// RULE_22: clock select 00 fast osc, 01 system, 10 logic cell 1, 11 pin.
// RULE_23: enabled low increment write loads buffer on second tick, else immediately.
// RULE_24: overflow in the cycle of a software clear leaves the flag set.
module oomc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic fast_osc_clk,
   input wire logic logic_cell1_output,
   input wire logic osc_clock_pin,
   output logic osc_out,
   output logic osc_pin_out,
   output logic osc_pin_oe,
   output logic irq_request,
   output logic fast_osc_keep_on
);
   import oomc_pkg::*;

   // control state
   logic module_on;
   logic pin_drive_enable;
   logic output_invert;
   logic pulse_mode_select;
   logic [2:0] pulse_width_select;
   oomc_cks_t clock_source_select;
   logic [7:0] inc_low;
   logic [7:0] inc_high;
   logic overflow_irq_flag;
   logic overflow_irq_enable;
   logic peripheral_irq_enable;
   logic global_irq_enable;
   logic next_module_on;
   logic next_pin_drive_enable;
   logic next_output_invert;
   logic next_pulse_mode_select;
   logic [2:0] next_pulse_width_select;
   oomc_cks_t next_clock_source_select;
   logic [7:0] next_inc_low;
   logic [7:0] next_inc_high;
   logic next_overflow_irq_flag;
   logic next_overflow_irq_enable;
   logic next_peripheral_irq_enable;
   logic next_global_irq_enable;

   // bus state
   logic wr_pend;
   logic [7:0] wr_addr;
   logic next_wr_pend;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic bus_take;

   // output state
   logic src_prev;
   logic next_src_prev;
   logic src_level;
   logic osc_tick;
   logic raw_out;
   logic next_raw_out;
   logic [7:0] pulse_count;
   logic [7:0] next_pulse_count;
   logic next_osc_out;
   logic next_irq_request;
   logic next_fast_osc_keep_on;
   logic overflow_irq_event;
   logic polarity_irq;

   // accumulator interface
   logic [ACC_W-1:0] acc;
   logic accumulator_carry;
   logic acc_wr;
   logic [ACC_W-1:0] acc_wdata;
   logic inc_low_wr;
   logic [INC_W-1:0] inc_wdata;

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h00000000;
      case (a)
         OFS_CONTROL: begin
            w[BIT_MODULE_ON] = module_on;
            w[BIT_PIN_DRIVE] = pin_drive_enable;
            w[BIT_OUT_STATUS] = osc_out; // RULE_10
            w[BIT_INVERT] = output_invert;
            w[BIT_PULSE_MODE] = pulse_mode_select;
         end
         OFS_CLOCK: begin
            w[PWS_LSB +: 3] = pulse_width_select;
            w[CKS_LSB +: 2] = clock_source_select;
         end
         OFS_ACC_LOW: w[7:0] = acc[7:0];
         OFS_ACC_HIGH: w[7:0] = acc[15:8];
         OFS_ACC_UPPER: w[3:0] = acc[19:16];
         OFS_INC_LOW: w[7:0] = inc_low;
         OFS_INC_HIGH: w[7:0] = inc_high;
         OFS_IRQ_FLAG: w[BIT_IRQ_FLAG] = overflow_irq_flag;
         OFS_IRQ_ENABLE: begin
            w[BIT_IRQ_IE] = overflow_irq_enable;
            w[BIT_IRQ_PIE] = peripheral_irq_enable;
            w[BIT_IRQ_GIE] = global_irq_enable;
         end
         default: w = 32'h00000000;
      endcase
      return w;
   endfunction

   // ahb-lite slave, zero wait states, always okay
   always_comb begin
      bus_take = hsel & hready & htrans[1];
      next_wr_pend = bus_take & hwrite;
      next_wr_addr = wr_addr;
      next_hrdata = hrdata;
      if (bus_take) begin
         next_wr_addr = {haddr[7:2], 2'b00};
         if (!hwrite) begin
            next_hrdata = read_word({haddr[7:2], 2'b00});
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= RST_BYTE;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // register writes and the interrupt flag
   always_comb begin
      next_module_on = module_on;
      next_pin_drive_enable = pin_drive_enable;
      next_output_invert = output_invert;
      next_pulse_mode_select = pulse_mode_select;
      next_pulse_width_select = pulse_width_select;
      next_clock_source_select = clock_source_select;
      next_inc_low = inc_low;
      next_inc_high = inc_high;
      next_overflow_irq_flag = overflow_irq_flag;
      next_overflow_irq_enable = overflow_irq_enable;
      next_peripheral_irq_enable = peripheral_irq_enable;
      next_global_irq_enable = global_irq_enable;
      acc_wr = 1'b0;
      acc_wdata = acc;
      inc_low_wr = 1'b0;
      inc_wdata = {inc_high, inc_low};
      if (wr_pend) begin
         case (wr_addr)
            OFS_CONTROL: begin
               next_module_on = hwdata[BIT_MODULE_ON]; // RULE_18
               next_pin_drive_enable = hwdata[BIT_PIN_DRIVE]; // RULE_19
               next_output_invert = hwdata[BIT_INVERT];
               next_pulse_mode_select = hwdata[BIT_PULSE_MODE];
            end
            OFS_CLOCK: begin
               next_pulse_width_select = hwdata[PWS_LSB +: 3]; // RULE_06
               next_clock_source_select = oomc_cks_t'(hwdata[CKS_LSB +: 2]);
            end
            OFS_ACC_LOW: begin
               acc_wr = 1'b1;
               acc_wdata = {acc[19:8], hwdata[7:0]};
            end
            OFS_ACC_HIGH: begin
               acc_wr = 1'b1;
               acc_wdata = {acc[19:16], hwdata[7:0], acc[7:0]};
            end
            OFS_ACC_UPPER: begin
               acc_wr = 1'b1;
               acc_wdata = {hwdata[3:0], acc[15:0]};
            end
            OFS_INC_LOW: begin
               next_inc_low = hwdata[7:0];
               inc_low_wr = 1'b1; // RULE_23
               inc_wdata = {inc_high, hwdata[7:0]};
            end
            OFS_INC_HIGH: next_inc_high = hwdata[7:0];
            OFS_IRQ_FLAG: next_overflow_irq_flag = hwdata[BIT_IRQ_FLAG]; // RULE_14
            OFS_IRQ_ENABLE: begin
               next_overflow_irq_enable = hwdata[BIT_IRQ_IE];
               next_peripheral_irq_enable = hwdata[BIT_IRQ_PIE];
               next_global_irq_enable = hwdata[BIT_IRQ_GIE];
            end
            default: begin
            end
         endcase
      end
      if (overflow_irq_event) begin
         next_overflow_irq_flag = 1'b1; // RULE_12 RULE_24
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         module_on <= 1'b0; // RULE_15
         pin_drive_enable <= 1'b0;
         output_invert <= 1'b0;
         pulse_mode_select <= 1'b0;
         pulse_width_select <= 3'h0;
         clock_source_select <= OOMC_CKS_FAST_OSC;
         inc_low <= RST_BYTE;
         inc_high <= RST_BYTE;
         overflow_irq_flag <= 1'b0;
         overflow_irq_enable <= 1'b0;
         peripheral_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end else begin
         module_on <= next_module_on;
         pin_drive_enable <= next_pin_drive_enable;
         output_invert <= next_output_invert;
         pulse_mode_select <= next_pulse_mode_select;
         pulse_width_select <= next_pulse_width_select;
         clock_source_select <= next_clock_source_select;
         inc_low <= next_inc_low;
         inc_high <= next_inc_high;
         overflow_irq_flag <= next_overflow_irq_flag;
         overflow_irq_enable <= next_overflow_irq_enable;
         peripheral_irq_enable <= next_peripheral_irq_enable;
         global_irq_enable <= next_global_irq_enable;
      end
   end

   oomc_accum u_accum (
      .hclk(hclk),
      .hresetn(hresetn),
      .osc_tick(osc_tick),
      .module_on(module_on),
      .inc_low_wr(inc_low_wr),
      .inc_wdata(inc_wdata),
      .acc_wr(acc_wr),
      .acc_wdata(acc_wdata),
      .acc(acc),
      .accumulator_carry(accumulator_carry)
   );

   // oscillator tick: rising edge of the selected source, sampled on hclk; every hclk cycle when the system clock is selected
   always_comb begin
      case (clock_source_select)
         OOMC_CKS_FAST_OSC: src_level = fast_osc_clk; // RULE_22
         OOMC_CKS_SYSTEM: src_level = 1'b1;
         OOMC_CKS_LOGIC_CELL1: src_level = logic_cell1_output;
         OOMC_CKS_CLOCK_PIN: src_level = osc_clock_pin;
         default: src_level = 1'b0;
      endcase
      next_src_prev = src_level;
      if (clock_source_select == OOMC_CKS_SYSTEM) begin
         osc_tick = module_on; // RULE_22 RULE_18
      end else begin
         osc_tick = module_on & src_level & ~src_prev; // RULE_16
      end
      overflow_irq_event = accumulator_carry;
   end

   // output stage
   always_comb begin
      next_raw_out = raw_out;
      next_pulse_count = pulse_count;
      if (!module_on) begin
         next_raw_out = 1'b0; // RULE_18
         next_pulse_count = RST_PULSE_COUNT;
      end else if (!pulse_mode_select) begin
         next_pulse_count = RST_PULSE_COUNT;
         if (accumulator_carry) begin
            next_raw_out = ~raw_out; // RULE_01 RULE_02
         end
      end else if (accumulator_carry) begin
         next_raw_out = 1'b1; // RULE_03 RULE_04 RULE_05
         next_pulse_count = 8'((9'h001 << pulse_width_select) - 9'h001); // RULE_21
      end else if (osc_tick) begin
         if (pulse_count == RST_PULSE_COUNT) begin
            next_raw_out = 1'b0; // RULE_03
         end else begin
            next_pulse_count = pulse_count - 8'h01;
         end
      end
      next_osc_out = next_raw_out ^ next_output_invert; // RULE_08
      polarity_irq = (next_osc_out != osc_out) & (next_output_invert != output_invert)
         & overflow_irq_enable & global_irq_enable; // RULE_09
      next_irq_request = module_on & (overflow_irq_flag | polarity_irq) & overflow_irq_enable
         & peripheral_irq_enable & global_irq_enable; // RULE_13
      next_fast_osc_keep_on = module_on
         & (clock_source_select == OOMC_CKS_FAST_OSC); // RULE_17
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev <= 1'b0;
         raw_out <= 1'b0;
         pulse_count <= RST_PULSE_COUNT;
         osc_out <= 1'b0;
         osc_pin_out <= 1'b0;
         osc_pin_oe <= 1'b0;
         irq_request <= 1'b0;
         fast_osc_keep_on <= 1'b0;
      end else begin
         src_prev <= next_src_prev;
         raw_out <= next_raw_out;
         pulse_count <= next_pulse_count;
         osc_out <= next_osc_out; // RULE_11
         osc_pin_out <= next_osc_out & next_pin_drive_enable;
         osc_pin_oe <= next_pin_drive_enable; // RULE_19
         irq_request <= next_irq_request;
         fast_osc_keep_on <= next_fast_osc_keep_on;
      end
   end
endmodule

// File: bench/oomc_props.sv
`timescale 1ns/1ps
module oomc_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic fast_osc_clk,
   input wire logic logic_cell1_output,
   input wire logic osc_clock_pin,
   input wire logic osc_out,
   input wire logic osc_pin_out,
   input wire logic osc_pin_oe,
   input wire logic irq_request,
   input wire logic fast_osc_keep_on
);
   import oomc_pkg::*;
   logic wr_q;
   logic rd_q;
   logic [7:0] wa_q;
   logic [7:0] ctl_sh;
   logic [7:0] clk_sh;
   logic [7:0] en_sh;
   logic [7:0] st_cnt;
   logic [7:0] hi_len;
   logic take;
   logic raw;
   logic pulse_on;
   assign take = hsel && hready && htrans[1];
   assign raw = osc_out ^ ctl_sh[BIT_INVERT];
   assign pulse_on = st_cnt == 8'hff && ctl_sh[7] && ctl_sh[0] && clk_sh[1:0] == 2'h1;
   // shadow of the control, clock and irq enable bytes written over the bus, and cycles since the last write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         wa_q <= 8'h00;
         ctl_sh <= 8'h00;
         clk_sh <= 8'h00;
         en_sh <= 8'h00;
         st_cnt <= 8'h00;
         hi_len <= 8'h00;
      end else begin
         wr_q <= take && hwrite;
         rd_q <= take && !hwrite && haddr == OFS_CONTROL;
         wa_q <= haddr;
         if (wr_q && wa_q == OFS_CONTROL) ctl_sh <= hwdata[7:0];
         if (wr_q && wa_q == OFS_CLOCK) clk_sh <= hwdata[7:0];
         if (wr_q && wa_q == OFS_IRQ_ENABLE) en_sh <= hwdata[7:0];
         st_cnt <= wr_q ? 8'h00 : st_cnt + {7'h0, st_cnt != 8'hff};
         hi_len <= raw ? hi_len + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero wait okay");
   status_read_a: assert property (rd_q |-> hrdata[5] == $past(osc_out) && hrdata[31:8] == 24'h0)
      else $error("status bit does not show output level");
   pin_off_a: assert property (!osc_pin_oe |-> !osc_pin_out)
      else $error("pin driven while disconnected");
   pin_bit_a: assert property (st_cnt >= 8'h02 |-> osc_pin_oe == ctl_sh[BIT_PIN_DRIVE])
      else $error("pin enable differs from control bit");
   off_level_a: assert property (st_cnt >= 8'h02 && !ctl_sh[7] |-> osc_out == ctl_sh[4])
      else $error("disabled output not at inverse level");
   keep_on_a: assert property (st_cnt >= 8'h02 |->
      fast_osc_keep_on == (ctl_sh[7] && clk_sh[1:0] == 2'h0))
      else $error("fast oscillator keep on wrong");
   irq_gate_a: assert property (st_cnt >= 8'h02 && irq_request |-> en_sh[0] && en_sh[2])
      else $error("request without enables");
   pulse_len_a: assert property (pulse_on && $fell(raw) |-> hi_len == 8'h01 << clk_sh[7:5])
      else $error("pulse length wrong");
   read_c: cover property (rd_q);
   pulse_c: cover property (pulse_on && $fell(raw));
   irq_c: cover property (irq_request);
endmodule

// File: bench/oomc_src_model.sv
`timescale 1ns/1ps
module oomc_src_model (
   input wire logic hclk,
   input wire logic hresetn,
   output logic src_clk
);
   logic [1:0] div;
   // free running source, one rising edge every four bus clocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
      end
   end
   assign src_clk = div[1];
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
   import oomc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout, hresp, osc_out, osc_pin_out, osc_pin_oe, irq_request, fast_osc_keep_on;
   logic src_clk;
   int irq_cnt = 0;
   logic inv;
   logic [15:0] rnd;
   logic [31:0] q;
   int error_cnt = 0;
   int n_compared = 0;
   int n;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   always @(posedge hclk) if (irq_request === 1'b1) irq_cnt <= irq_cnt + 1;
   oomc_src_model oomc_src_model_inst (.hclk, .hresetn, .src_clk);
   oomc_top oomc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fast_osc_clk(src_clk),
      .logic_cell1_output(src_clk), .osc_clock_pin(src_clk), .osc_out, .osc_pin_out,
      .osc_pin_oe, .irq_request, .fast_osc_keep_on);
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wrap_up;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hready !== 1'b1 && i < 100);
      if (i >= 100) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   // cycles until the output next changes
   task automatic gap(output int k);
      logic v;
      v = osc_out;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (osc_out === v && k < 4000);
      if (k >= 4000) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   initial begin
      rnd = 16'h0002;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a <= 36; a += 4) rdchk(8'(a), 32'h0, "reset_value");
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         wr(OFS_ACC_LOW + 8'(4 * k), {16'h0, rnd});
         rdchk(OFS_ACC_LOW + 8'(4 * k), {24'h0, rnd[7:0] & (k == 2 ? 8'h0f : 8'hff)}, "acc");
      end
      wr(OFS_IRQ_ENABLE, 32'h7);
      wr(OFS_CONTROL, 32'h20);
      rdchk(OFS_CONTROL, 32'h0, "status_ro");
      // the request is gated by module on, so switch on before flipping polarity
      wr(OFS_CONTROL, 32'h80);
      n = irq_cnt;
      wr(OFS_CONTROL, 32'h90);
      rdchk(OFS_CONTROL, 32'hb0, "status_inverted");
      chk("polarity_irq", 32'(irq_cnt - n), 32'h1);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_INC_HIGH, 32'h10);
      wr(OFS_INC_LOW, 32'h0);
      wr(OFS_CLOCK, 32'h1);
      wr(OFS_CONTROL, 32'hc0);
      gap(n);
      gap(n);
      chk("toggle_first", 32'(n), 32'h100);
      gap(n);
      chk("toggle_second", 32'(n), 32'h100);
      rdchk(OFS_IRQ_FLAG, 32'h1, "flag_set");
      chk("pin_level", {31'h0, osc_pin_out}, {31'h0, osc_out});
      // increment change while running goes through the working buffer
      wr(OFS_INC_HIGH, 32'h20);
      wr(OFS_INC_LOW, 32'h0);
      gap(n);
      gap(n);
      chk("inc_reload", 32'(n), 32'h80);
      wr(OFS_INC_HIGH, 32'h10);
      wr(OFS_INC_LOW, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_IRQ_ENABLE, 32'(c));
         repeat (2) @(posedge hclk);
         chk("irq_gate", {31'h0, irq_request}, {31'h0, c == 7});
      end
      wr(OFS_CONTROL, 32'h0);
      repeat (2) @(posedge hclk);
      chk("irq_module_off", {31'h0, irq_request}, 32'h0);
      wr(OFS_IRQ_FLAG, 32'h0);
      rdchk(OFS_IRQ_FLAG, 32'h0, "flag_cleared");
      wr(OFS_IRQ_ENABLE, 32'h0);
      for (int c = 0; c < 8; c++) begin
         rnd = lfsr(rnd);
         inv = rnd[0];
         wr(OFS_CLOCK, 32'(c << 5 | 1));
         wr(OFS_CONTROL, {24'h0, 8'h81 | {3'h0, inv, 4'h0}});
         gap(n);
         gap(n);
         if ((osc_out ^ inv) !== 1'b1) gap(n);
         gap(n);
         chk("pulse_width", 32'(n), 32'h1 << c);
      end
      wr(OFS_CONTROL, 32'h80);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_CLOCK, 32'(c));
         gap(n);
         gap(n);
         chk("source_gap", 32'(n), c == 1 ? 32'h100 : 32'h400);
         chk("keep_on", {31'h0, fast_osc_keep_on}, {31'h0, c == 0});
      end
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(OFS_CONTROL, 32'h0, "second_reset");
      wrap_up();
   end
endmodule
bind oomc_top oomc_props oomc_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .fast_osc_clk, .logic_cell1_output,
   .osc_clock_pin, .osc_out, .osc_pin_out, .osc_pin_oe, .irq_request, .fast_osc_keep_on);
